// ===== logic/output_pulse_modulator_params.svh
// How it works
// - Four selectable output function types
// - Analog type copies input unchanged
// - Pulse active time is period times percent
// - Zero percent still pulses one sample period
// - Full percent holds pulse whole period
// - Pulse period settable zero to 1000 s
// - Raise on rising, lower on falling input
// - Accumulate increments, trip above threshold
// - Inside deadband clear accumulator, outputs off
// - Stepping direction changes at most per 2 s
// - Hold full-travel time 15 to 1000 s
// - With feedback report feedback as output
// - Manual without feedback reports raise/lower
// - No feedback disables restart and forced
// - Proportional-only holds increment at zero
// - Auto applies deadband to control error
// - Manual and forced both count non-auto
// - Non-auto no feedback uses sample difference
// - Auto no feedback uses control increment
// - Non-auto feedback uses value minus position
// - Restart steps toward value, then manual
`ifndef OUTPUT_PULSE_MODULATOR_PARAMS_SVH
`define OUTPUT_PULSE_MODULATOR_PARAMS_SVH
`define OFS_CONFIG       8'h00
`define OFS_CONTROL_VAL  8'h04
`define OFS_CONTROL_INC  8'h08
`define OFS_CONTROL_ERR  8'h0C
`define OFS_POSITION     8'h10
`define OFS_PULSE_PERIOD 8'h14
`define OFS_SAMPLE_PER   8'h18
`define OFS_FULL_TRAVEL  8'h1C
`define OFS_TRIP_THRESH  8'h20
`define OFS_DEADBAND     8'h24
`define OFS_RESTART_VAL  8'h28
`define OFS_SETTLE_WIN   8'h2C
`define OFS_STATUS       8'h30
`define OFS_ACCUM        8'h34
`define CFG_TYPE_LSB     0
`define CFG_FEEDBACK_BIT 2
`define CFG_MODE_LSB     3
`define CFG_PONLY_BIT    5
`define CFG_RESTART_BIT  6
`define PCT_FULL         16'h03E8
`define PULSE_PERIOD_MAX 10'h3E8
`define TRAVEL_MIN       10'h00F
`define TRAVEL_MAX       10'h3E8
`define TRIP_MIN         5'h03
`define TRIP_MAX         5'h1E
`define DEADBAND_MAX     7'h64
`define RST_PULSE_PERIOD 10'h032
`define RST_SAMPLE_PER   16'h0064
`define RST_FULL_TRAVEL  10'h03C
`define RST_TRIP_THRESH  5'h05
`define RST_DEADBAND     7'h0A
`define RST_SETTLE_WIN   16'h000A
`define MS_PER_S         20'h003E8
`define INTERLOCK_MS     12'h7D0
`define CLK_PERIOD_NS    50
`define MS_IN_NS         1000000
`define MS_CYCLES        (`MS_IN_NS / `CLK_PERIOD_NS)
`define ACC_LIMIT        18'sh007D0
`endif

// ===== logic/output_pulse_modulator_pkg.sv
package output_pulse_modulator_pkg;
    // Output function type and control mode selections.
    typedef enum logic [1:0] {FN_ANALOG, FN_STEPPING, FN_PULSE,
                              FN_SPLIT} fn_type;
    typedef enum logic [1:0] {MD_AUTO, MD_MANUAL, MD_FORCED,
                              MD_SPARE} mode_type;
    // Whole state of the block, registered in one place.
    typedef struct packed {
        logic [14:0]        ms_cnt;
        logic [15:0]        samp_cnt;
        fn_type             fn;
        logic               fb_en;
        mode_type           mode;
        logic               p_only;
        logic               restarting;
        logic [15:0]        cv;
        logic signed [15:0] ctrl_inc;
        logic signed [15:0] ctrl_err;
        logic [15:0]        position;
        logic [9:0]         pulse_period;
        logic [15:0]        sample_period;
        logic [9:0]         full_travel;
        logic [4:0]         trip;
        logic [6:0]         deadband;
        logic [15:0]        restart_val;
        logic [15:0]        settle;
        logic [15:0]        prev_cv;
        logic signed [17:0] acc;
        logic [19:0]        elapsed;
        logic [19:0]        step_ms;
        logic               dir_raise;
        logic [11:0]        ilk_ms;
        logic               ap_valid;
        logic               ap_write;
        logic [7:0]         ap_addr;
        logic [31:0]        rdata;
        logic               pulse;
        logic               raise;
        logic               lower;
        logic [15:0]        analog;
    } state_type;
endpackage

// ===== logic/output_pulse_modulator.sv
`timescale 1ns/1ps
`include "output_pulse_modulator_params.svh"
module output_pulse_modulator
    import output_pulse_modulator_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic             PULSE_OUT,
    output logic             RAISE_OUT,
    output logic             LOWER_OUT,
    output logic      [15:0] ANALOG_OUT
);

    state_type s_reg;
    state_type s_next;
    logic      tick;
    logic      in_band;

    //------------------------------------------------------------
    // Register read mux
    //------------------------------------------------------------

    // Value that a read of the given offset returns.
    function automatic logic [31:0] read_word(state_type s,
                                              logic [7:0] a,
                                              logic [15:0] rep,
                                              logic ind);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            `OFS_CONFIG: begin
                w[1:0] = s.fn;
                w[`CFG_FEEDBACK_BIT] = s.fb_en;
                w[4:3] = s.mode;
                w[`CFG_PONLY_BIT] = s.p_only;
                w[`CFG_RESTART_BIT] = s.restarting;
            end
            `OFS_CONTROL_VAL:  w[15:0] = s.cv;
            `OFS_CONTROL_INC:  w[15:0] = s.ctrl_inc;
            `OFS_CONTROL_ERR:  w[15:0] = s.ctrl_err;
            `OFS_POSITION:     w[15:0] = s.position;
            `OFS_PULSE_PERIOD: w[9:0]  = s.pulse_period;
            `OFS_SAMPLE_PER:   w[15:0] = s.sample_period;
            `OFS_FULL_TRAVEL:  w[9:0]  = s.full_travel;
            `OFS_TRIP_THRESH:  w[4:0]  = s.trip;
            `OFS_DEADBAND:     w[6:0]  = s.deadband;
            `OFS_RESTART_VAL:  w[15:0] = s.restart_val;
            `OFS_SETTLE_WIN:   w[15:0] = s.settle;
            `OFS_STATUS: begin
                w[0] = s.pulse;
                w[1] = s.raise;
                w[2] = s.lower;
                w[3] = s.restarting;
                w[4] = ind;
                w[31:16] = rep;
            end
            `OFS_ACCUM:        w = {{14{s.acc[17]}}, s.acc};
            default:           w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // Magnitude of a signed quantity.
    function automatic logic [17:0] mag(logic signed [17:0] v);
        return v[17] ? 18'(-v) : 18'(v);
    endfunction

    //------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------

    // Bus slave, sample timebase, pulse and stepping engines.
    always_comb begin
        logic [31:0]        wd;
        logic [19:0]        samp;
        logic [19:0]        period_ms;
        logic [19:0]        on_ms;
        logic [19:0]        el_sum;
        logic signed [17:0] inc;
        logic signed [17:0] acc_sum;
        logic [17:0]        band;
        logic               want_raise;
        logic               non_auto;
        logic               fb_use;
        logic [15:0]        rep;
        logic               ind;
        logic [35:0]        travel;
        mode_type           eff_mode;
        s_next     = s_reg;
        wd         = HWDATA;
        samp       = {4'h0, s_reg.sample_period};
        period_ms  = 20'(s_reg.pulse_period * `MS_PER_S);
        on_ms      = 20'(s_reg.pulse_period * s_reg.cv);
        el_sum     = s_reg.elapsed + samp;
        inc        = 18'sh00000;
        acc_sum    = s_reg.acc;
        band       = 18'h00000;
        want_raise = 1'b0;
        fb_use     = s_reg.fb_en;
        travel     = 36'h0_0000_0000;
        in_band    = 1'b0;
        tick       = 1'b0;
        rep        = 16'h0000;
        eff_mode = (!fb_use && s_reg.mode == MD_FORCED) ? MD_AUTO
                                                        : s_reg.mode;
        non_auto = (eff_mode != MD_AUTO);
        if (fb_use) begin
            rep = s_reg.position;
        end else if (s_reg.fn == FN_STEPPING) begin
            rep = 16'h0000;
        end else begin
            rep = s_reg.cv;
        end
        ind = !fb_use && s_reg.fn == FN_STEPPING &&
              eff_mode == MD_MANUAL;

        // Address phase: latch the request and prepare read data.
        if (HREADY) begin
            s_next.ap_valid = HSEL && HTRANS[1];
            s_next.ap_write = HWRITE;
            s_next.ap_addr  = HADDR[7:0];
            s_next.rdata    = read_word(s_reg, HADDR[7:0], rep, ind);
        end
        // Data phase of a write: store with range clamping.
        if (s_reg.ap_valid && s_reg.ap_write) begin
            case (s_reg.ap_addr)
                `OFS_CONFIG: begin
                    s_next.fn     = fn_type'(wd[1:0]);
                    s_next.fb_en  = wd[`CFG_FEEDBACK_BIT];
                    s_next.mode   = mode_type'(wd[4:3]);
                    s_next.p_only = wd[`CFG_PONLY_BIT];
                    s_next.restarting = wd[`CFG_RESTART_BIT] &&
                                        wd[`CFG_FEEDBACK_BIT];
                end
                `OFS_CONTROL_VAL: s_next.cv = wd[15:0];
                `OFS_CONTROL_INC: s_next.ctrl_inc = wd[15:0];
                `OFS_CONTROL_ERR: s_next.ctrl_err = wd[15:0];
                `OFS_POSITION:    s_next.position = wd[15:0];
                `OFS_PULSE_PERIOD: s_next.pulse_period =
                    (wd > 32'(`PULSE_PERIOD_MAX)) ? `PULSE_PERIOD_MAX
                                                  : wd[9:0];
                `OFS_SAMPLE_PER: s_next.sample_period =
                    (wd[15:0] == 16'h0000) ? 16'h0001 : wd[15:0];
                `OFS_FULL_TRAVEL: s_next.full_travel =
                    (wd < 32'(`TRAVEL_MIN)) ? `TRAVEL_MIN :
                    (wd > 32'(`TRAVEL_MAX)) ? `TRAVEL_MAX : wd[9:0];
                `OFS_TRIP_THRESH: s_next.trip =
                    (wd < 32'(`TRIP_MIN)) ? `TRIP_MIN :
                    (wd > 32'(`TRIP_MAX)) ? `TRIP_MAX : wd[4:0];
                `OFS_DEADBAND: s_next.deadband =
                    (wd == 32'h0) ? 7'h01 :
                    (wd > 32'(`DEADBAND_MAX)) ? `DEADBAND_MAX
                                              : wd[6:0];
                `OFS_RESTART_VAL: s_next.restart_val = wd[15:0];
                `OFS_SETTLE_WIN:  s_next.settle = wd[15:0];
                default: ;
            endcase
        end

        if (s_reg.ms_cnt == 15'(MS_CYCLES - 1)) begin
            s_next.ms_cnt = 15'h0000;
            if (s_reg.samp_cnt + 16'h0001 >= s_reg.sample_period) begin
                s_next.samp_cnt = 16'h0000;
                tick = 1'b1;
            end else begin
                s_next.samp_cnt = s_reg.samp_cnt + 16'h0001;
            end
        end else begin
            s_next.ms_cnt = s_reg.ms_cnt + 15'h0001;
        end

        // Increment source for the stepping engine.
        if (s_reg.p_only) begin
            inc = 18'sh00000;
        end else if (s_reg.restarting) begin
            inc = 18'(signed'({2'b00, s_reg.restart_val}) -
                      signed'({2'b00, s_reg.position}));
        end else if (non_auto && fb_use) begin
            inc = 18'(signed'({2'b00, s_reg.cv}) -
                      signed'({2'b00, s_reg.position}));
        end else if (non_auto) begin
            inc = 18'(signed'({2'b00, s_reg.cv}) -
                      signed'({2'b00, s_reg.prev_cv}));
        end else begin
            inc = 18'(s_reg.ctrl_inc);
        end
        // deadband on control error in auto
        if (eff_mode == MD_AUTO && !s_reg.restarting) begin
            band = mag(18'(s_reg.ctrl_err));
        end else begin
            band = mag(inc);
        end
        in_band = (s_reg.fn == FN_STEPPING) &&
                  (band < {11'h000, s_reg.deadband}) &&
                  !(non_auto && !fb_use && !s_reg.restarting);

        if (tick) begin
            s_next.prev_cv = s_reg.cv;
            if ({8'h00, s_reg.ilk_ms} + samp >= {8'h00, `INTERLOCK_MS})
                s_next.ilk_ms = `INTERLOCK_MS;
            else
                s_next.ilk_ms = s_reg.ilk_ms + samp[11:0];

            if (s_reg.cv >= `PCT_FULL)
                on_ms = period_ms;
            else if (on_ms < samp)
                on_ms = samp;
            s_next.elapsed = (el_sum >= period_ms) ? 20'h00000 : el_sum;
            s_next.pulse = (s_reg.fn == FN_PULSE) &&
                           (s_next.elapsed < on_ms);

            if (s_reg.restarting &&
                mag(inc) <= {2'b00, s_reg.settle}) begin
                s_next.restarting = 1'b0;
                s_next.mode = MD_MANUAL;
            end

            if (in_band || s_reg.fn != FN_STEPPING) begin
                s_next.acc = 18'sh00000;
                s_next.step_ms = 20'h00000;
            end else if (s_reg.step_ms != 20'h00000) begin
                acc_sum = s_reg.acc + inc;
                s_next.step_ms = (s_reg.step_ms > samp) ?
                                 s_reg.step_ms - samp : 20'h00000;
            end else begin
                acc_sum = s_reg.acc + inc;
                want_raise = !acc_sum[17];
                if (mag(acc_sum) > {13'h0000, s_reg.trip} &&
                    (want_raise == s_reg.dir_raise ||
                     s_reg.ilk_ms == `INTERLOCK_MS)) begin
                    if (want_raise != s_reg.dir_raise)
                        s_next.ilk_ms = 12'h000;
                    s_next.dir_raise = want_raise;
                    travel = 36'(mag(acc_sum) * s_reg.full_travel);
                    s_next.step_ms = (travel > 36'h0_000F_FFFF) ?
                                     20'hFFFFF : travel[19:0];
                    acc_sum = 18'sh00000;
                end
            end
            if (!in_band && s_reg.fn == FN_STEPPING) begin
                if (acc_sum > `ACC_LIMIT)
                    s_next.acc = `ACC_LIMIT;
                else if (acc_sum < -`ACC_LIMIT)
                    s_next.acc = -`ACC_LIMIT;
                else
                    s_next.acc = acc_sum;
            end
            s_next.raise = (s_next.step_ms != 20'h00000) &&
                           s_next.dir_raise;
            s_next.lower = (s_next.step_ms != 20'h00000) &&
                           !s_next.dir_raise;
        end
        if (s_reg.fn != FN_PULSE)
            s_next.pulse = 1'b0; // No stale pulse after a type change.
        s_next.analog = (s_reg.fn == FN_ANALOG) ? s_reg.cv : 16'h0000;
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------

    // Single register stage for the whole block state.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_reg <= '0;
            s_reg.fn            <= FN_ANALOG;
            s_reg.mode          <= MD_AUTO;
            s_reg.pulse_period  <= `RST_PULSE_PERIOD;
            s_reg.sample_period <= `RST_SAMPLE_PER;
            s_reg.full_travel   <= `RST_FULL_TRAVEL;
            s_reg.trip          <= `RST_TRIP_THRESH;
            s_reg.deadband      <= `RST_DEADBAND;
            s_reg.settle        <= `RST_SETTLE_WIN;
            s_reg.ilk_ms        <= `INTERLOCK_MS;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state flip-flops; HREADYOUT and HRESP are constants.
    assign HRDATA     = s_reg.rdata;
    assign HREADYOUT  = 1'b1;
    assign HRESP      = 1'b0;
    assign PULSE_OUT  = s_reg.pulse;
    assign RAISE_OUT  = s_reg.raise;
    assign LOWER_OUT  = s_reg.lower;
    assign ANALOG_OUT = s_reg.analog;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_analog_copy: assert property (s_reg.fn == FN_ANALOG |=>
        ANALOG_OUT == $past(s_reg.cv))
        else $error("analog output differs from input");
    a_pulse_full: assert property (tick && s_reg.fn == FN_PULSE &&
        s_reg.cv >= `PCT_FULL && s_reg.pulse_period != 10'h000
        |=> PULSE_OUT)
        else $error("full input did not hold pulse");
    a_pulse_min: assert property ($past(tick) &&
        s_reg.fn == FN_PULSE && $stable(s_reg.fn) &&
        s_reg.elapsed == 20'h00000 |-> PULSE_OUT)
        else $error("period start without pulse");
    a_pulse_type: assert property (PULSE_OUT |->
        $past(s_reg.fn) == FN_PULSE || s_reg.fn == FN_PULSE)
        else $error("pulse in wrong type");
    a_step_excl: assert property (!(RAISE_OUT && LOWER_OUT))
        else $error("raise and lower together");
    a_band_clear: assert property (tick && in_band |=>
        s_reg.acc == 18'sh00000 && !RAISE_OUT && !LOWER_OUT)
        else $error("deadband left output active");
    a_dir_interlock: assert property ($changed(s_reg.dir_raise) |->
        $past(s_reg.ilk_ms) == `INTERLOCK_MS)
        else $error("direction changed inside interlock");
    a_ponly_hold: assert property (s_reg.p_only &&
        s_reg.acc == 18'sh00000 && s_reg.fn == FN_STEPPING
        |=> s_reg.acc == 18'sh00000)
        else $error("increment moved accumulator");
    a_restart_done: assert property ($fell(s_reg.restarting) &&
        !$past(s_reg.ap_valid) |-> s_reg.mode == MD_MANUAL)
        else $error("restart did not enter manual");
    a_bus_ready: assert property (HREADYOUT && !HRESP)
        else $error("bus slave not ready");

    c_pulse_on: cover property ($rose(PULSE_OUT));
    c_raise_on: cover property ($rose(RAISE_OUT));
    c_lower_on: cover property ($rose(LOWER_OUT));
    c_restart:  cover property ($fell(s_reg.restarting));

endmodule // output_pulse_modulator

// ===== test/actuator_model.sv
`timescale 1ns/1ps
// Motor actuator that travels while a stepping output is on.
module actuator_model #(
    parameter int STEP_CLKS = 4
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        raise,
    input  wire logic        lower,
    output logic      [15:0] position
);
    int cnt;

    // One tenth of a percent per STEP_CLKS clocks, kept inside span.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt      <= 0;
            position <= 16'h0000;
        end else if ((raise ^ lower) && cnt == STEP_CLKS - 1) begin
            cnt <= 0;
            if (raise && position < 16'h03E8) begin
                position <= position + 16'h0001;
            end else if (lower && position > 16'h0000) begin
                position <= position - 16'h0001;
            end
        end else if (raise ^ lower) begin
            cnt <= cnt + 1;
        end
    end
endmodule // actuator_model

// ===== test/tb_output_pulse_modulator.sv
`timescale 1ns/1ps
`include "output_pulse_modulator_params.svh"
module tb_output_pulse_modulator
    import output_pulse_modulator_pkg::*;
;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] wd;
        logic [31:0] exp;
    } row_type;
    logic        CLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0]  HTRANS = 2'h0;
    logic        HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic        HREADYOUT;
    logic        HRESP;
    logic        PULSE_OUT;
    logic        RAISE_OUT;
    logic        LOWER_OUT;
    logic [15:0] ANALOG_OUT;
    logic [15:0] pos;
    logic [31:0] rd;
    int          errors = 0;
    int          check_count = 0;
    int          hi;
    time         tr;
    int          pcv [3] = '{600, 0, 1000};
    int          phi [3] = '{2400, 4, 4000};
    row_type     rows [9] = '{
        '{`OFS_PULSE_PERIOD, 32'h7D0, 32'h3E8},
        '{`OFS_PULSE_PERIOD, 32'h0, 32'h0},
        '{`OFS_FULL_TRAVEL, 32'h5, 32'hF},
        '{`OFS_FULL_TRAVEL, 32'h7D0, 32'h3E8},
        '{`OFS_TRIP_THRESH, 32'h1, 32'h3},
        '{`OFS_TRIP_THRESH, 32'h32, 32'h1E},
        '{`OFS_DEADBAND, 32'hC8, 32'h64},
        '{8'h40, 32'h55, 32'h0},
        '{`OFS_STATUS, 32'hFF, 32'h0}};
    row_type     rst_rows [6] = '{
        '{`OFS_CONFIG, 32'h0, 32'h0},
        '{`OFS_PULSE_PERIOD, 32'h0, 32'h32},
        '{`OFS_SAMPLE_PER, 32'h0, 32'h64},
        '{`OFS_FULL_TRAVEL, 32'h0, 32'h3C},
        '{`OFS_TRIP_THRESH, 32'h0, 32'h5},
        '{`OFS_DEADBAND, 32'h0, 32'hA}};

    // Free-running 20 MHz clock.
    always #25 CLK = ~CLK;

    output_pulse_modulator #(.MS_CYCLES(4)) uut (
        .CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PULSE_OUT(PULSE_OUT),
        .RAISE_OUT(RAISE_OUT), .LOWER_OUT(LOWER_OUT),
        .ANALOG_OUT(ANALOG_OUT));

    actuator_model act (.clk(CLK), .rst_n(RST_N), .raise(RAISE_OUT),
        .lower(LOWER_OUT), .position(pos));

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stuck();
        check(32'h0, 32'h1);
        report_and_stop();
    endtask

    // One single AHB transfer; the bus holds each phase until ready.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int k;
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR <= {24'h0, a};
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (HREADYOUT !== 1'b1 && k < 40);
        if (k >= 40) stuck();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do begin
            @(posedge CLK);
            k++;
        end while (HREADYOUT !== 1'b1 && k < 80);
        rd = HRDATA;
        if (k >= 80) stuck();
    endtask

    // Waits a bounded time for the raise or the lower output.
    task automatic wait_out(input logic low_side, input int lim);
        int k;
        k = 0;
        while ((low_side ? LOWER_OUT : RAISE_OUT) !== 1'b1) begin
            @(posedge CLK);
            k++;
            if (k > lim) stuck();
        end
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (90000) @(posedge CLK);
        stuck();
    end

    // Main sequence.
    initial begin
        repeat (16) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].wd);
            bus(1'b0, rows[i].a, 32'h0);
            check(rd, rows[i].exp); // clamps
        end
        $display("Register rows done");
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        foreach (rst_rows[i]) begin
            bus(1'b0, rst_rows[i].a, 32'h0);
            check(rd, rst_rows[i].exp); // defaults
        end
        $display("Reset test done");
        bus(1'b1, `OFS_CONTROL_VAL, 32'd600);
        repeat (3) @(posedge CLK);
        check(ANALOG_OUT, 32'd600); // copy
        bus(1'b1, `OFS_SAMPLE_PER, 32'h1);
        bus(1'b1, `OFS_PULSE_PERIOD, 32'h1);
        bus(1'b1, `OFS_CONFIG, 32'h2);
        foreach (pcv[i]) begin
            bus(1'b1, `OFS_CONTROL_VAL, pcv[i]);
            repeat (4000) @(posedge CLK);
            hi = 0;
            repeat (4000) begin
                @(posedge CLK);
                if (PULSE_OUT === 1'b1) hi++;
            end
            check(hi, phi[i]); // width
        end
        check(ANALOG_OUT, 32'h0); // idle
        $display("Pulse test done");
        bus(1'b1, `OFS_CONFIG, 32'h1);
        bus(1'b1, `OFS_CONTROL_ERR, 32'd100);
        bus(1'b1, `OFS_CONTROL_INC, 32'd10);
        wait_out(1'b0, 4000);
        tr = $time;
        check(LOWER_OUT, 32'h0); // raise
        bus(1'b1, `OFS_CONTROL_INC, 32'h0);
        bus(1'b1, `OFS_CONTROL_INC, 32'hFFF6);
        wait_out(1'b1, 20000);
        check($time - tr >= 399500, 32'h1); // spacing
        check(RAISE_OUT, 32'h0); // lower
        bus(1'b1, `OFS_CONTROL_ERR, 32'd5);
        bus(1'b1, `OFS_CONTROL_INC, 32'd10);
        repeat (400) @(posedge CLK);
        check({RAISE_OUT, LOWER_OUT}, 32'h0); // quiet
        bus(1'b0, `OFS_ACCUM, 32'h0);
        check(rd, 32'h0); // cleared
        $display("Stepping test done");
        bus(1'b1, `OFS_CONFIG, 32'h21);
        bus(1'b1, `OFS_CONTROL_ERR, 32'd100);
        repeat (400) @(posedge CLK);
        check({RAISE_OUT, LOWER_OUT}, 32'h0); // still
        bus(1'b1, `OFS_CONTROL_INC, 32'h0);
        bus(1'b1, `OFS_CONFIG, 32'h5);
        bus(1'b1, `OFS_POSITION, {16'h0, pos});
        bus(1'b0, `OFS_STATUS, 32'h0);
        check(rd[31:16], pos); // feedback
        bus(1'b1, `OFS_CONFIG, 32'h1);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check(rd[31:16], 32'h0); // zero
        bus(1'b1, `OFS_CONFIG, 32'h9);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check(rd[4], 32'h1); // indication
        check(rd[31:16], 32'h0); // zero level
        bus(1'b1, `OFS_CONTROL_VAL, 32'd900);
        wait_out(1'b1, 40);
        check(RAISE_OUT, 32'h0); // sample difference
        bus(1'b1, `OFS_CONFIG, 32'h41);
        bus(1'b0, `OFS_CONFIG, 32'h0);
        check(rd, 32'h1); // no restart
        bus(1'b1, `OFS_RESTART_VAL, 32'h100);
        bus(1'b1, `OFS_POSITION, 32'h100);
        bus(1'b1, `OFS_CONFIG, 32'h45);
        repeat (12) @(posedge CLK);
        bus(1'b0, `OFS_CONFIG, 32'h0);
        check(rd, 32'hD); // restart done
        check({RAISE_OUT, LOWER_OUT}, 32'h0); // settled
        $display("Indication test done");
        report_and_stop();
    end
endmodule // tb_output_pulse_modulator
